// [mixer_gain_pkg.sv]
// Package with register map, field layout and reset values of the mixer gain registers.
package mixer_gain_pkg;
  // Printed indices are not all multiples of four, so byte address is index times four.
  localparam logic [7:0] IDX_BEEP = 8'h0a;
  localparam logic [7:0] IDX_PHONE = 8'h0c;
  localparam logic [7:0] IDX_MIC = 8'h0e;
  localparam logic [7:0] IDX_LINE = 8'h10;
  localparam logic [7:0] IDX_CD = 8'h12;
  localparam logic [7:0] IDX_VIDEO = 8'h14;
  localparam logic [7:0] IDX_AUX = 8'h16;
  localparam logic [7:0] IDX_PCM = 8'h18;
  localparam logic [7:0] IDX_RECSRC = 8'h1a;
  localparam logic [7:0] IDX_RECGAIN = 8'h1c;
  localparam logic [7:0] IDX_MICREC = 8'h1e;
  localparam logic [7:0] IDX_GP = 8'h20;
  localparam logic [7:0] IDX_MISC = 8'h40;

  // Writable bit masks; all other bits read zero.
  localparam logic [15:0] MASK_BEEP = 16'h801e;
  localparam logic [15:0] MASK_MONO = 16'h801f;
  localparam logic [15:0] MASK_MIC = 16'h805f;
  localparam logic [15:0] MASK_STEREO = 16'h9f1f;
  localparam logic [15:0] MASK_RECSRC = 16'h0707;
  localparam logic [15:0] MASK_RECGAIN = 16'h8f0f;
  localparam logic [15:0] MASK_MICREC = 16'h800f;
  localparam logic [15:0] MASK_GP = 16'hf380;
  localparam logic [15:0] MASK_MISC = 16'h0001;

  localparam logic [15:0] RST_BEEP = 16'h0000;
  localparam logic [15:0] RST_MONO = 16'h8008;
  localparam logic [15:0] RST_STEREO = 16'h8808;
  localparam logic [15:0] RST_RECSRC = 16'h0000;
  localparam logic [15:0] RST_RECGAIN = 16'h8000;
  localparam logic [15:0] RST_GP = 16'h0000;
  localparam logic [15:0] RST_MISC = 16'h0000;

  localparam int MUTE_BIT = 15;
  localparam int MIC_BOOST_HIGH_BIT = 6;
  localparam int MIC_BOOST_LOW_BIT = 0;
  localparam int GP_PCM_POST_3D_BIT = 15;
  localparam int GP_WIDEN_BIT = 14;
  localparam int GP_SPATIAL_BIT = 13;
  localparam int GP_BASS_BIT = 12;
  localparam int GP_MONO_SRC_BIT = 9;
  localparam int GP_MIC_PICK_BIT = 8;
  localparam int GP_LOOPBACK_BIT = 7;
  localparam int NUM_STEREO = 5;

  // Level codes are in 1.5 dB units; boost in 10 dB units.
  localparam logic [5:0] UNITY_CODE = 6'h08;

  typedef struct packed {
    logic mute;
    logic [4:0] left_level;
    logic [4:0] right_level;
  } stereo_gain_t;

  typedef struct packed {
    logic beep_mute;
    logic [3:0] beep_tone_atten;
    logic phone_mute;
    logic [4:0] phone_level;
    logic mic_mute;
    logic [1:0] mic_boost_steps;
    logic [4:0] mic_level;
    logic signed [7:0] mic_gain_half_db;
  } mono_gain_t;

  typedef struct packed {
    logic [2:0] left_record_pick;
    logic [2:0] right_record_pick;
    logic rec_mute;
    logic [3:0] rec_left;
    logic [3:0] rec_right;
    logic mic_rec_mute;
    logic [3:0] mic_record_level;
  } record_t;

  typedef struct packed {
    logic pcm_post_3d;
    logic mono_widen_enable;
    logic spatial_enhance_enable;
    logic bass_boost_enable;
    logic mono_mixer_source_sel;
    logic mic_input_pick;
    logic adc_dac_loopback;
  } path_t;
endpackage : mixer_gain_pkg

// [mixer_gain_control_regs.sv]
// APB register bank for the analog input mixer and record path controls.
//
// Behaviour
// - Beep register holds mute in bit 15 and 4-bit 3 dB attenuation in bits 4..1.
// - Beep register resets to 0000h, unmuted, no attenuation.
// - While link reset is asserted, beep register does not affect beep level or mute.
// - Phone register holds mute and 5-bit level, 1.5 dB steps, 01000 unity.
// - Phone and microphone registers reset to 8008h, unity and muted.
// - Mic register bit 6 adds 20 dB; with the low boost bit, 0..30 dB.
// - Mic gain equals level code gain plus selected boost, up to +42 dB.
// - Stereo gain registers reset to 8808h, unity both channels, muted.
// - Stereo registers decoded at 10h, 12h, 14h, 16h and 18h.
// - Record source holds 3-bit left pick bits 10..8, right pick bits 2..0.
// - Record source resets to 0000h, both channels take microphone.
// - Stereo record gain holds mute, 4-bit left and right gains, 1.5 dB steps.
// - Stereo and mic record gain registers reset to 8000h, zero gain, muted.
// - Mic record gain holds mute and 4-bit gain in bits 3..0.
// - Path bit 15 mixes PCM output after the 3D stage when set.
// - Path bits 14, 13, 12 enable widening, spatial and bass boost.
// - Mono output source bit picks mic boost stage when set, else mono mixer.
// - Mic pick bit selects second mic when set; mute acts on selected input.
// - Loopback bit routes ADC output to DAC input; path register resets 0000h.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module mixer_gain_control_regs (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link reset, active low, from the serial link
  input wire logic link_reset_n,
  // Analog control outputs
  output mixer_gain_pkg::mono_gain_t mono_ctrl,
  output mixer_gain_pkg::stereo_gain_t [mixer_gain_pkg::NUM_STEREO-1:0] stereo_ctrl,
  output mixer_gain_pkg::record_t record_ctrl,
  output mixer_gain_pkg::path_t path_ctrl
);
  import mixer_gain_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } bus_state_t;

  bus_state_t state_q;
  logic [15:0] beep_q, phone_q, mic_q, recsrc_q, recgain_q, micrec_q, gp_q, misc_q;
  logic [15:0] stereo_q [NUM_STEREO];
  logic access;
  logic wr;
  logic [7:0] idx;
  logic hit;
  logic [15:0] rd_word;
  logic [15:0] wmask_lanes;

  // Merge lane-enabled write data into the old value, keeping only writable bits.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [15:0] lanes, input logic [15:0] keep);
    merge = ((old & ~lanes) | (wd & lanes)) & keep;
  endfunction : merge

  // Level code to half-dB units: +24 at 00000, minus 3 per step.
  function automatic logic signed [7:0] level_half_db(input logic [4:0] code);
    level_half_db = 8'sd24 - 8'(signed'({3'b000, code}) * 3);
  endfunction : level_half_db

  // Stereo register index decode; returns NUM_STEREO when not a stereo index.
  function automatic logic [2:0] stereo_slot(input logic [7:0] i);
    case (i)
      IDX_LINE: stereo_slot = 3'd0;
      IDX_CD: stereo_slot = 3'd1;
      IDX_VIDEO: stereo_slot = 3'd2;
      IDX_AUX: stereo_slot = 3'd3;
      IDX_PCM: stereo_slot = 3'd4;
      default: stereo_slot = 3'(NUM_STEREO);
    endcase
  endfunction : stereo_slot

  assign access = psel && penable && (state_q == ST_IDLE);
  assign wr = access && pwrite && hit && (paddr[1:0] == 2'b00);
  assign idx = paddr[9:2];
  assign wmask_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    hit = 1'b1;
    rd_word = 16'h0000;
    case (idx)
      IDX_BEEP: rd_word = beep_q;
      IDX_PHONE: rd_word = phone_q;
      IDX_MIC: rd_word = mic_q;
      IDX_RECSRC: rd_word = recsrc_q;
      IDX_RECGAIN: rd_word = recgain_q;
      IDX_MICREC: rd_word = micrec_q;
      IDX_GP: rd_word = gp_q;
      IDX_MISC: rd_word = misc_q;
      default: begin
        if (stereo_slot(idx) != 3'(NUM_STEREO)) begin
          rd_word = stereo_q[stereo_slot(idx)];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // One-wait-state slave: answer in the cycle after the access phase starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (psel && penable) state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && (!hit || paddr[1:0] != 2'b00);
      if (access && !pwrite && hit) begin
        prdata <= {16'h0000, rd_word};
      end else if (access) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beep_q <= RST_BEEP;
      phone_q <= RST_MONO;
      mic_q <= RST_MONO;
      recsrc_q <= RST_RECSRC;
      recgain_q <= RST_RECGAIN;
      micrec_q <= RST_RECGAIN;
      gp_q <= RST_GP;
      misc_q <= RST_MISC;
    end else if (wr) begin
      case (idx)
        IDX_BEEP: beep_q <= merge(beep_q, pwdata[15:0], wmask_lanes, MASK_BEEP);
        IDX_PHONE: phone_q <= merge(phone_q, pwdata[15:0], wmask_lanes, MASK_MONO);
        IDX_MIC: mic_q <= merge(mic_q, pwdata[15:0], wmask_lanes, MASK_MIC);
        IDX_RECSRC: recsrc_q <= merge(recsrc_q, pwdata[15:0], wmask_lanes, MASK_RECSRC);
        IDX_RECGAIN: recgain_q <= merge(recgain_q, pwdata[15:0], wmask_lanes, MASK_RECGAIN);
        IDX_MICREC: micrec_q <= merge(micrec_q, pwdata[15:0], wmask_lanes, MASK_MICREC);
        IDX_GP: gp_q <= merge(gp_q, pwdata[15:0], wmask_lanes, MASK_GP);
        IDX_MISC: misc_q <= merge(misc_q, pwdata[15:0], wmask_lanes, MASK_MISC);
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_STEREO; i++) begin
        stereo_q[i] <= RST_STEREO;
      end
    end else if (wr && stereo_slot(idx) != 3'(NUM_STEREO)) begin
      stereo_q[stereo_slot(idx)] <= merge(stereo_q[stereo_slot(idx)], pwdata[15:0],
                                          wmask_lanes, MASK_STEREO);
    end
  end

  // Beep and mono inputs; beep falls back to unmuted full level during link reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mono_ctrl <= '0;
    end else begin
      mono_ctrl.beep_mute <= link_reset_n ? beep_q[MUTE_BIT] : 1'b0;
      mono_ctrl.beep_tone_atten <= link_reset_n ? beep_q[4:1] : 4'h0;
      mono_ctrl.phone_mute <= phone_q[MUTE_BIT];
      mono_ctrl.phone_level <= phone_q[4:0];
      mono_ctrl.mic_mute <= mic_q[MUTE_BIT];
      mono_ctrl.mic_boost_steps <= {1'b0, misc_q[MIC_BOOST_LOW_BIT]}
                                   + {mic_q[MIC_BOOST_HIGH_BIT], 1'b0};
      mono_ctrl.mic_level <= mic_q[4:0];
      // Boost of 10 dB is 20 half-dB units per step.
      mono_ctrl.mic_gain_half_db <= level_half_db(mic_q[4:0])
                                    + 8'(misc_q[MIC_BOOST_LOW_BIT] ? 20 : 0)
                                    + 8'(mic_q[MIC_BOOST_HIGH_BIT] ? 40 : 0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stereo_ctrl <= '0;
    end else begin
      for (int i = 0; i < NUM_STEREO; i++) begin
        stereo_ctrl[i].mute <= stereo_q[i][MUTE_BIT];
        stereo_ctrl[i].left_level <= stereo_q[i][12:8];
        stereo_ctrl[i].right_level <= stereo_q[i][4:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      record_ctrl <= '0;
    end else begin
      record_ctrl.left_record_pick <= recsrc_q[10:8];
      record_ctrl.right_record_pick <= recsrc_q[2:0];
      record_ctrl.rec_mute <= recgain_q[MUTE_BIT];
      record_ctrl.rec_left <= recgain_q[11:8];
      record_ctrl.rec_right <= recgain_q[3:0];
      record_ctrl.mic_rec_mute <= micrec_q[MUTE_BIT];
      record_ctrl.mic_record_level <= micrec_q[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      path_ctrl <= '0;
    end else begin
      path_ctrl.pcm_post_3d <= gp_q[GP_PCM_POST_3D_BIT];
      path_ctrl.mono_widen_enable <= gp_q[GP_WIDEN_BIT];
      path_ctrl.spatial_enhance_enable <= gp_q[GP_SPATIAL_BIT];
      path_ctrl.bass_boost_enable <= gp_q[GP_BASS_BIT];
      path_ctrl.mono_mixer_source_sel <= gp_q[GP_MONO_SRC_BIT];
      path_ctrl.mic_input_pick <= gp_q[GP_MIC_PICK_BIT];
      path_ctrl.adc_dac_loopback <= gp_q[GP_LOOPBACK_BIT];
    end
  end
endmodule : mixer_gain_control_regs

// [mixer_gain_checker_properties.sv]
// Assertion checker for the ports of the mixer gain register bank.
`timescale 1ns/10ps
module mixer_gain_checker (
  // Clock, reset and bus
  input logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_reset_n,
  input logic [9:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [3:0] pstrb,
  // Control outputs
  input mixer_gain_pkg::mono_gain_t mono_ctrl,
  input mixer_gain_pkg::stereo_gain_t [mixer_gain_pkg::NUM_STEREO-1:0] stereo_ctrl,
  input mixer_gain_pkg::record_t record_ctrl,
  input mixer_gain_pkg::path_t path_ctrl
);
  import mixer_gain_pkg::*;
  logic [15:0] d_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Outputs follow a write a clock later, so the accepted data is kept here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) d_q <= 16'h0000;
    else if (pready) d_q <= pwdata[15:0];
  end
  sequence s_wr(logic [7:0] i);
    pready && pwrite && !pslverr && pstrb == 4'hf && link_reset_n && paddr == {i, 2'b00};
  endsequence
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_fixed_zero; pready && !pwrite |-> (prdata & ~{16'h0, MASK_BEEP & MASK_MONO}) == 0 ||
    paddr != {IDX_BEEP, 2'b00}; endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bit read high");
  property p_beep_hold; !link_reset_n ##1 !link_reset_n |->
    !mono_ctrl.beep_mute && mono_ctrl.beep_tone_atten == 4'h0; endproperty
  a_beep_hold: assert property (p_beep_hold) else $error("beep active in link reset");
  property p_mic_gain; $past(presetn) |-> mono_ctrl.mic_gain_half_db ==
    8'(24 - 3 * mono_ctrl.mic_level + 20 * mono_ctrl.mic_boost_steps); endproperty
  a_mic_gain: assert property (p_mic_gain) else $error("mic gain wrong");
  property p_beep_wr; s_wr(IDX_BEEP) |-> ##[1:2]
    {mono_ctrl.beep_mute, mono_ctrl.beep_tone_atten} == {d_q[15], d_q[4:1]}; endproperty
  a_beep_wr: assert property (p_beep_wr) else $error("beep fields wrong");
  property p_line_wr; s_wr(IDX_LINE) |-> ##[1:2]
    stereo_ctrl[0] == {d_q[15], d_q[12:8], d_q[4:0]}; endproperty
  a_line_wr: assert property (p_line_wr) else $error("line gain wrong");
  property p_rec_wr; s_wr(IDX_RECSRC) |-> ##[1:2]
    {record_ctrl.left_record_pick, record_ctrl.right_record_pick} == {d_q[10:8], d_q[2:0]};
  endproperty
  a_rec_wr: assert property (p_rec_wr) else $error("record pick wrong");
  property p_path_wr; s_wr(IDX_GP) |-> ##[1:2] path_ctrl == {d_q[15:12], d_q[9:7]}; endproperty
  a_path_wr: assert property (p_path_wr) else $error("path bits wrong");
endmodule : mixer_gain_checker
bind mixer_gain_control_regs mixer_gain_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .pslverr, .link_reset_n, .paddr, .pwdata, .prdata, .pstrb, .mono_ctrl,
  .stereo_ctrl, .record_ctrl, .path_ctrl);

// [tb.sv]
// Self-checking bench with a register model for the mixer gain register bank.
`timescale 1ns/10ps
module tb;
  import mixer_gain_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_reset_n, er;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  mono_gain_t mono_ctrl;
  stereo_gain_t [NUM_STEREO-1:0] stereo_ctrl;
  record_t record_ctrl;
  path_t path_ctrl;
  int miscompares, comparisons, dummy;
  logic [7:0] ix [13] = '{IDX_BEEP, IDX_PHONE, IDX_MIC, IDX_LINE, IDX_CD, IDX_VIDEO, IDX_AUX,
    IDX_PCM, IDX_RECSRC, IDX_RECGAIN, IDX_MICREC, IDX_GP, IDX_MISC};
  logic [15:0] mk [13] = '{MASK_BEEP, MASK_MONO, MASK_MIC, MASK_STEREO, MASK_STEREO,
    MASK_STEREO, MASK_STEREO, MASK_STEREO, MASK_RECSRC, MASK_RECGAIN, MASK_MICREC, MASK_GP,
    MASK_MISC};
  logic [15:0] rv [13] = '{RST_BEEP, RST_MONO, RST_MONO, RST_STEREO, RST_STEREO, RST_STEREO,
    RST_STEREO, RST_STEREO, RST_RECSRC, RST_RECGAIN, RST_RECGAIN, RST_GP, RST_MISC};
  logic [15:0] mdl [13];
  mixer_gain_control_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .link_reset_n, .mono_ctrl, .stereo_ctrl, .record_ctrl,
    .path_ctrl);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    // A timeout ends the run here, so nothing is driven after the verdict.
    if (pready !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t bus timeout", $time);
      give_verdict();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic wr(input int k, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, {ix[k], 2'b00}, d, s);
    if (s[0]) mdl[k][7:0] = d[7:0] & mk[k][7:0];
    if (s[1]) mdl[k][15:8] = d[15:8] & mk[k][15:8];
    chk(er, 1'b0);
  endtask : wr
  task automatic rdk(input int k);
    apb(1'b0, {ix[k], 2'b00}, 32'h0000_0000, 4'hf);
    chk({er, rd}, {17'h0_0000, mdl[k]});
  endtask : rdk
  task automatic outs();
    logic [15:0] m [13];
    logic [1:0] bst;
    repeat (2) @(posedge pclk);
    m = mdl;
    if (!link_reset_n) m[0] = 16'h0000;
    bst = {m[2][6], m[12][0]};
    chk(mono_ctrl, {m[0][15], m[0][4:1], m[1][15], m[1][4:0], m[2][15], bst, m[2][4:0],
      8'(24 - 3 * m[2][4:0] + 20 * bst)});
    for (int i = 0; i < 5; i++) chk(stereo_ctrl[i], {m[3+i][15], m[3+i][12:8], m[3+i][4:0]});
    chk(record_ctrl, {m[8][10:8], m[8][2:0], m[9][15], m[9][11:8], m[9][3:0], m[10][15],
      m[10][3:0]});
    chk(path_ctrl, {m[11][15:12], m[11][9:7]});
  endtask : outs
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    link_reset_n = 1'b1;
    presetn = 1'b0;
    miscompares = 0;
    comparisons = 0;
    dummy = $urandom(32'h93ff);
    @(posedge pclk);
    for (int p = 0; p < 2; p++) begin
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      mdl = rv;
      @(posedge pclk);
      for (int k = 0; k < 13; k++) rdk(k);
      outs();
      $display("Test reset values done");
      for (int r = 0; r < 3; r++) begin
        for (int k = 0; k < 13; k++) begin
          wr(k, r == 0 ? 32'hffff_ffff : $urandom, r == 2 ? 4'($urandom) : 4'hf);
          rdk(k);
        end
        outs();
      end
      for (int c = 0; c < 8; c++) begin
        wr(8, {21'h0, 3'(c), 5'h0, 3'(7 - c)}, 4'hf);
        wr(12, c, 4'hf);
        wr(2, {25'h0, c[1], 1'b0, 5'(c * 4)}, 4'hf);
        outs();
      end
      $display("Test writes and codes done");
      for (int i = 0; i < 4; i++) begin
        apb(i[0], i < 2 ? 10'h008 : {IDX_BEEP, 2'b10}, 32'hffff_ffff, 4'hf);
        // A misaligned read of a mapped word still returns that word along with the error.
        chk({er, rd}, {1'b1, 16'h0000, (i == 2) ? mdl[0] : 16'h0000});
      end
      wr(0, 32'h0000_801e, 4'hf);
      link_reset_n <= 1'b0;
      outs();
      rdk(0);
      link_reset_n <= 1'b1;
      outs();
      for (int k = 0; k < 13; k++) rdk(k);
      $display("Test errors and link reset done");
    end
    give_verdict();
  end
endmodule : tb
